// [rtl/acc_pkg.sv]
// shared constants and types of the converter control block
package acc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CONFIG      = 8'h04;
	localparam logic [7:0] OFS_COMPARE     = 8'h08;
	localparam logic [7:0] OFS_RESULT_HI   = 8'h0C;
	localparam logic [7:0] OFS_RESULT_LO   = 8'h10;
	localparam logic [7:0] OFS_PIN_LOW     = 8'h14;
	localparam logic [7:0] OFS_PIN_MID     = 8'h18;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h20;

	// conversion_status_control fields
	localparam int unsigned SC_DONE_BIT  = 7;
	localparam int unsigned SC_IRQEN_BIT = 6;
	localparam int unsigned SC_CONT_BIT  = 5;
	localparam int unsigned CHAN_W       = 5;
	localparam logic [4:0]  CHAN_OFF     = 5'h1F;

	// configuration fields
	localparam int unsigned CFG_DIV_LSB    = 0;
	localparam int unsigned CFG_HWTRIG_BIT = 2;
	localparam int unsigned CFG_CMPEN_BIT  = 3;
	localparam int unsigned CFG_CMPGE_BIT  = 4;
	localparam int unsigned CFG_BUSY_BIT   = 7;
	localparam int unsigned CFG_W          = 5;

	// interrupt status and mask fields
	localparam int unsigned IRQ_DONE_BIT   = 0;
	localparam int unsigned IRQ_MISSED_BIT = 1;
	localparam int unsigned IRQ_W          = 2;

	// values after reset
	localparam logic [4:0] CHAN_RESET     = 5'h1F;
	localparam logic [4:0] CFG_RESET      = 5'h00;
	localparam logic [7:0] PIN_RESET      = 8'h00;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h1;

	// conversion clock ticks per conversion
	localparam int unsigned CONV_TICKS = 12;

	typedef enum logic {
		ACC_IDLE,
		ACC_CONVERT
	} acc_seq_state_t;
endpackage

// [rtl/acc_clk_div.sv]
// conversion clock divider producing a one-cycle enable
`timescale 1ns/1ps
module acc_clk_div
	import acc_pkg::*;
(
	input  wire logic       mclk,    // system clock
	input  wire logic       resetn,  // async reset, active low
	input  wire logic [1:0] divSel,  // 0..3 gives divide by 1,2,4,8
	output logic            tick     // one-cycle conversion clock enable
);
	typedef struct packed {
		logic [2:0] cnt;
	} acc_div_state_t;

	acc_div_state_t state_q;
	acc_div_state_t state_d;
	logic [2:0]     divMask;

	// mask of counter bits that must be all ones for a tick
	always_comb begin
		case (divSel)
			2'h0: divMask = 3'h0;
			2'h1: divMask = 3'h1;
			2'h2: divMask = 3'h3;
			default: divMask = 3'h7;
		endcase
	end

	// free-running counter
	always_comb begin
		state_d = state_q;
		state_d.cnt = state_q.cnt + 3'h1;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign tick = (state_q.cnt & divMask) == divMask; // [R12]
endmodule

// [rtl/acc_conv_seq.sv]
// conversion sequencer: counts ticks of one conversion
`timescale 1ns/1ps
module acc_conv_seq
	import acc_pkg::*;
#(
	parameter int unsigned TICKS = CONV_TICKS
) (
	input  wire logic mclk,        // system clock
	input  wire logic resetn,      // async reset, active low
	input  wire logic tick,        // conversion clock enable
	input  wire logic start,       // start pulse, beats abort
	input  wire logic abort,       // drop the conversion in progress
	input  wire logic continuous,  // restart after each completion
	output logic      busy,        // converter powered and converting
	output logic      done         // one-cycle completion pulse
);
	localparam int unsigned CNT_W = (TICKS > 1) ? $clog2(TICKS) : 1;

	typedef struct packed {
		acc_seq_state_t   state;
		logic [CNT_W-1:0] cnt;
		logic             done;
	} acc_seq_reg_t;

	acc_seq_reg_t state_q;
	acc_seq_reg_t state_d;

	// idle until started, count ticks, then finish or go again
	always_comb begin
		state_d = state_q;
		state_d.done = 1'b0;
		case (state_q.state)
			ACC_IDLE: begin
				state_d.cnt = '0;
			end
			ACC_CONVERT: begin
				if (tick) begin
					if (state_q.cnt == CNT_W'(TICKS - 1)) begin
						state_d.done = 1'b1;
						state_d.cnt = '0;
						if (!continuous) begin
							state_d.state = ACC_IDLE; // [R9]
						end
					end else begin
						state_d.cnt = state_q.cnt + CNT_W'(1);
					end
				end
			end
			default: begin
				state_d.state = ACC_IDLE;
			end
		endcase
		if (abort) begin
			state_d.state = ACC_IDLE; // [R8]
			state_d.cnt = '0;
			state_d.done = 1'b0;
		end
		if (start) begin
			state_d.state = ACC_CONVERT;
			state_d.cnt = '0;
			state_d.done = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{state: ACC_IDLE, cnt: '0, done: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	assign busy = state_q.state == ACC_CONVERT;
	assign done = state_q.done;
endmodule

// [rtl/acc_ctrl_top.sv]
// converter control: registers, triggering, flag, interrupt, pin gating
//
// What this block does
// [R1] compare off: every finished conversion sets the done flag, bit 7.
// [R2] compare on: done flag set only when the compare result is true.
// [R3] writing status/control or reading result low byte clears the flag.
// [R4] flag setting with interrupt enable bit 6 high raises the interrupt.
// [R5] continuous bit 5: low one conversion per start, high keeps going.
// [R6] bits 4:0 pick the input channel by its own number.
// [R7] channel code all ones powers the converter off and isolates input.
// [R8] stopping continuous mode with all ones starts no extra conversion.
// [R9] single mode drops to low power after each conversion.
// [R10] low pin register bits 0 and 1 disable port control of pins 0, 1.
// [R11] mid pin register bits govern channels 8 to 15, bit 7 is 15.
// [R12] conversion clock divides by 1, 2, 4 or 8.
// [R13] disabled pin: output off, input reads zero, pullup off.
// [R14] software mode: status/control write not all ones starts conversion.
// [R15] hardware mode: trigger rising edge starts, ignored while busy.
// [R16] unlisted channel codes act as valid channels, passed through.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module acc_ctrl_top
	import acc_pkg::*;
#(
	parameter int unsigned RES_W = 10,
	parameter int unsigned PIN_N = 16
) (
	input  wire logic             mclk,          // system clock
	input  wire logic             resetn,        // async reset, active low
	input  wire logic             psel,          // apb select
	input  wire logic             penable,       // apb access phase
	input  wire logic             pwrite,        // apb write
	input  wire logic [7:0]       paddr,         // apb byte address
	input  wire logic [31:0]      pwdata,        // apb write data
	output logic [31:0]           prdata,        // apb read data
	output logic                  pready,        // apb ready
	output logic                  pslverr,       // apb error, unmapped
	output logic                  irq,           // level interrupt
	input  wire logic             hwConvTrigger, // hardware trigger
	input  wire logic [RES_W-1:0] sampleData,    // converter result
	output logic                  convPowerOn,   // converter enabled
	output logic [CHAN_W-1:0]     muxSel,        // analog mux channel
	output logic                  inputIsolate,  // input cut off
	input  wire logic [PIN_N-1:0] portDriveEn,   // port wants to drive
	input  wire logic [PIN_N-1:0] portPullEn,    // port wants pullup
	input  wire logic [PIN_N-1:0] padIn,         // pad input level
	output logic [PIN_N-1:0]      padOutEnN,     // pad drive, low drives
	output logic [PIN_N-1:0]      padPullEn,     // pad pullup enable
	output logic [PIN_N-1:0]      portReadData   // value seen by port
);
	typedef struct packed {
		logic              doneFlag;
		logic              irqEnable;
		logic              contEnable;
		logic [CHAN_W-1:0] chanSel;
		logic [CFG_W-1:0]  cfg;
		logic [RES_W-1:0]  cmpVal;
		logic [RES_W-1:0]  result;
		logic [7:0]        pinLow;
		logic [7:0]        pinMid;
		logic [IRQ_W-1:0]  irqStatus;
		logic [IRQ_W-1:0]  irqMask;
		logic              trigPrev;
		logic [31:0]       rdData;
	} acc_top_state_t;

	acc_top_state_t    state_q;
	acc_top_state_t    state_d;
	logic              accessEn;
	logic              setupEn;
	logic              wrEn;
	logic              rdEn;
	logic              wrSc;
	logic              wrCfg;
	logic              wrCmp;
	logic              rdLo;
	logic              mapped;
	logic [31:0]       readMux;
	logic              chanOff;
	logic              hwMode;
	logic              trigRise;
	logic              swStart;
	logic              hwStart;
	logic              trigMissed;
	logic              seqStart;
	logic              seqAbort;
	logic              seqBusy;
	logic              seqDone;
	logic              convTick;
	logic              cmpTrue;
	logic              flagSet;
	logic [IRQ_W-1:0]  irqEvents;
	logic [IRQ_W-1:0]  irqClear;
	logic [15:0]       pinDisable;

	// apb phase and register strobes
	assign setupEn  = psel && !penable;
	assign accessEn = psel && penable;
	assign wrEn     = accessEn && pwrite;
	assign rdEn     = accessEn && !pwrite;
	assign wrSc     = wrEn && paddr == OFS_STATUS_CTRL;
	assign wrCfg    = wrEn && paddr == OFS_CONFIG;
	assign wrCmp    = wrEn && paddr == OFS_COMPARE;
	assign rdLo     = rdEn && paddr == OFS_RESULT_LO;

	// read mux and address map
	always_comb begin
		readMux = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			OFS_STATUS_CTRL: begin
				readMux[SC_DONE_BIT] = state_q.doneFlag;
				readMux[SC_IRQEN_BIT] = state_q.irqEnable;
				readMux[SC_CONT_BIT] = state_q.contEnable;
				readMux[CHAN_W-1:0] = state_q.chanSel;
			end
			OFS_CONFIG: begin
				readMux[CFG_W-1:0] = state_q.cfg;
				readMux[CFG_BUSY_BIT] = seqBusy;
			end
			OFS_COMPARE:    readMux[RES_W-1:0] = state_q.cmpVal;
			OFS_RESULT_HI:  readMux[RES_W-9:0] = state_q.result[RES_W-1:8];
			OFS_RESULT_LO:  readMux[7:0] = state_q.result[7:0];
			OFS_PIN_LOW:    readMux[7:0] = state_q.pinLow;
			OFS_PIN_MID:    readMux[7:0] = state_q.pinMid;
			OFS_IRQ_STATUS: readMux[IRQ_W-1:0] = state_q.irqStatus;
			OFS_IRQ_MASK:   readMux[IRQ_W-1:0] = state_q.irqMask;
			default:        mapped = 1'b0;
		endcase
	end

	// start, abort and trigger decisions
	assign chanOff    = state_q.chanSel == CHAN_OFF;
	assign hwMode     = state_q.cfg[CFG_HWTRIG_BIT];
	assign trigRise   = hwConvTrigger && !state_q.trigPrev;
	assign swStart    = wrSc && !hwMode
		&& pwdata[CHAN_W-1:0] != CHAN_OFF; // [R14] [R8]
	assign hwStart    = hwMode && trigRise && !seqBusy
		&& !chanOff && !wrSc; // [R15]
	assign trigMissed = hwMode && trigRise && seqBusy; // [R15]
	assign seqStart   = swStart || hwStart;
	assign seqAbort   = wrSc || wrCfg || wrCmp;

	// compare on completion, flag on a true compare or with compare off
	assign cmpTrue = state_q.cfg[CFG_CMPGE_BIT]
		? sampleData >= state_q.cmpVal
		: sampleData < state_q.cmpVal;
	assign flagSet = seqDone && (!state_q.cfg[CFG_CMPEN_BIT]
		|| cmpTrue); // [R1] [R2]

	// interrupt events and write-one-to-clear
	always_comb begin
		irqEvents = '0;
		irqEvents[IRQ_DONE_BIT] = flagSet && state_q.irqEnable; // [R4]
		irqEvents[IRQ_MISSED_BIT] = trigMissed;
		irqClear = '0;
		if (wrEn && paddr == OFS_IRQ_STATUS) begin
			irqClear = pwdata[IRQ_W-1:0];
		end
	end

	// register next state
	always_comb begin
		state_d = state_q;
		state_d.trigPrev = hwConvTrigger;
		if (setupEn) begin
			state_d.rdData = readMux;
		end
		if (wrSc) begin
			state_d.irqEnable = pwdata[SC_IRQEN_BIT];
			state_d.contEnable = pwdata[SC_CONT_BIT]; // [R5]
			state_d.chanSel = pwdata[CHAN_W-1:0]; // [R6] [R16]
		end
		if (wrCfg) begin
			state_d.cfg = pwdata[CFG_W-1:0];
		end
		if (wrCmp) begin
			state_d.cmpVal = pwdata[RES_W-1:0];
		end
		if (wrEn && paddr == OFS_PIN_LOW) begin
			state_d.pinLow = pwdata[7:0]; // [R10]
		end
		if (wrEn && paddr == OFS_PIN_MID) begin
			state_d.pinMid = pwdata[7:0]; // [R11]
		end
		if (wrEn && paddr == OFS_IRQ_MASK) begin
			state_d.irqMask = pwdata[IRQ_W-1:0];
		end
		// a completion in the clearing cycle still sets the flag
		if (flagSet) begin
			state_d.result = sampleData;
			state_d.doneFlag = 1'b1; // [R1] [R2]
		end else if (wrSc || rdLo) begin
			state_d.doneFlag = 1'b0; // [R3]
		end
		state_d.irqStatus = (state_q.irqStatus & ~irqClear) | irqEvents;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= '{
				doneFlag: 1'b0,
				irqEnable: 1'b0,
				contEnable: 1'b0,
				chanSel: CHAN_RESET,
				cfg: CFG_RESET,
				cmpVal: '0,
				result: '0,
				pinLow: PIN_RESET,
				pinMid: PIN_RESET,
				irqStatus: '0,
				irqMask: IRQ_MASK_RESET,
				trigPrev: 1'b0,
				rdData: 32'h0000_0000
			};
		end else begin
			state_q <= state_d;
		end
	end

	// conversion clock divider
	acc_clk_div u_div (
		.mclk   (mclk),
		.resetn (resetn),
		.divSel (state_q.cfg[CFG_DIV_LSB+1:CFG_DIV_LSB]), // [R12]
		.tick   (convTick)
	);

	// conversion sequencer
	acc_conv_seq #(
		.TICKS (CONV_TICKS)
	) u_seq (
		.mclk       (mclk),
		.resetn     (resetn),
		.tick       (convTick),
		.start      (seqStart),
		.abort      (seqAbort),
		.continuous (state_q.contEnable), // [R5]
		.busy       (seqBusy),
		.done       (seqDone)
	);

	// analog side: power only while converting, off code isolates
	assign convPowerOn  = seqBusy && !chanOff; // [R7] [R9]
	assign muxSel       = state_q.chanSel; // [R6]
	assign inputIsolate = chanOff; // [R7]

	// pin gating, one slice per analog pin
	assign pinDisable = {state_q.pinMid, state_q.pinLow};
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			assign padOutEnN[gi]    = pinDisable[gi]
				|| !portDriveEn[gi]; // [R13]
			assign padPullEn[gi]    = portPullEn[gi]
				&& !pinDisable[gi]; // [R13]
			assign portReadData[gi] = padIn[gi]
				&& !pinDisable[gi]; // [R13]
		end
	endgenerate

	// bus answer and interrupt
	assign prdata  = state_q.rdData;
	assign pready  = 1'b1;
	assign pslverr = accessEn && !mapped;
	assign irq     = |(state_q.irqStatus & state_q.irqMask);
endmodule

// [tb/acc_ctrl_monitor.sv]
// port-level checker of the converter control block
`timescale 1ns/1ps
module acc_ctrl_monitor
	import acc_pkg::*;
#(
	parameter int unsigned RES_W = 10, // result width
	parameter int unsigned PIN_N = 16  // pin count
) (
	input wire logic             mclk,         // system clock
	input wire logic             resetn,       // async reset, active low
	input wire logic             psel,         // apb select
	input wire logic             penable,      // apb access phase
	input wire logic             pwrite,       // apb write
	input wire logic [7:0]       paddr,        // apb address
	input wire logic [31:0]      pwdata,       // apb write data
	input wire logic             pready,       // apb ready
	input wire logic             pslverr,      // apb error
	input wire logic             irq,          // level interrupt
	input wire logic             convPowerOn,  // converter enabled
	input wire logic [CHAN_W-1:0] muxSel,      // mux channel
	input wire logic             inputIsolate, // input cut off
	input wire logic [PIN_N-1:0] portDriveEn,  // port drive request
	input wire logic [PIN_N-1:0] portPullEn,   // port pull request
	input wire logic [PIN_N-1:0] padIn,        // pad level
	input wire logic [PIN_N-1:0] padOutEnN,    // pad drive, low drives
	input wire logic [PIN_N-1:0] padPullEn,    // pad pullup
	input wire logic [PIN_N-1:0] portReadData  // port read value
);
	logic wrSc;   // status/control write completes
	logic wrMask; // interrupt mask write completes
	// completed register writes
	assign wrSc   = psel && penable && pwrite && paddr == OFS_STATUS_CTRL;
	assign wrMask = psel && penable && pwrite && paddr == OFS_IRQ_MASK;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_mux_follow: assert property (wrSc |=> muxSel == $past(pwdata[4:0]))
		else $error("channel select did not follow the write");
	a_off_stops: assert property (wrSc && pwdata[4:0] == CHAN_OFF
		|=> !convPowerOn [*8])
		else $error("converter ran after the off code");
	a_iso_code: assert property (inputIsolate == (muxSel == CHAN_OFF))
		else $error("isolation does not match the off code");
	a_off_power: assert property (inputIsolate |-> !convPowerOn)
		else $error("converter powered while isolated");
	a_drive_gate: assert property ((~portDriveEn & ~padOutEnN) == '0)
		else $error("pad driven without a port request");
	a_read_gate: assert property ((portReadData & ~padIn) == '0)
		else $error("port read shows a level the pad lacks");
	a_cut_pins: assert property ((padIn & ~portReadData
		& (padPullEn | ~padOutEnN)) == '0)
		else $error("cut pin still pulled or driven");
	a_mask_quiet: assert property (wrMask && pwdata[1:0] == 2'h0 |=> !irq)
		else $error("interrupt with every source masked");
	a_bad_addr: assert property (psel && penable && paddr > OFS_IRQ_MASK
		|-> pslverr && pready)
		else $error("unmapped access not refused");
endmodule

// [tb/acc_analog_model.sv]
// analog inputs and hardware trigger around the converter control
`timescale 1ns/1ps
module acc_analog_model
	import acc_pkg::*;
(
	input  wire logic       mclk,          // system clock
	input  wire logic       trigReq,       // level the bench asks for
	input  wire logic [4:0] muxSel,        // selected channel
	input  wire logic       inputIsolate,  // input cut off
	output logic            hwConvTrigger, // trigger to the block
	output logic [9:0]      sampleData     // converter result
);
	logic [9:0] junkQ = 10'h000; // changes every cycle
	// trigger follows the request one edge later
	always_ff @(posedge mclk) begin
		hwConvTrigger <= trigReq;
		junkQ         <= junkQ + 10'h155;
	end
	// channel-coded value while connected, garbage while isolated
	assign sampleData = inputIsolate ? junkQ : {muxSel, 5'h0A};
endmodule

// [tb/adc_status_channel_pin_control_bench.sv]
// self-checking bench of the converter control block
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module adc_status_channel_pin_control_bench;
	import acc_pkg::*;
	logic        mclk = 1'b0, resetn = 1'b0, trigReq = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, irq, hwConvTrigger, err;
	logic        convPowerOn, inputIsolate;
	logic [9:0]  sampleData;
	logic [4:0]  muxSel;
	logic [15:0] padOutEnN, padPullEn, portReadData;
	logic [15:0] portDriveEn = 16'hFFFF, portPullEn = 16'hFFFF;
	logic [15:0] padIn = 16'hFFFF;
	int          nMismatch = 0, numChecks = 0;
	acc_ctrl_top dut_u (.mclk(mclk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.hwConvTrigger(hwConvTrigger), .sampleData(sampleData),
		.convPowerOn(convPowerOn), .muxSel(muxSel),
		.inputIsolate(inputIsolate), .portDriveEn(portDriveEn),
		.portPullEn(portPullEn), .padIn(padIn), .padOutEnN(padOutEnN),
		.padPullEn(padPullEn), .portReadData(portReadData));
	acc_analog_model model_u (.mclk(mclk), .trigReq(trigReq),
		.muxSel(muxSel), .inputIsolate(inputIsolate),
		.hwConvTrigger(hwConvTrigger), .sampleData(sampleData));
	// clock
	always #4 mclk = ~mclk;
	// comparison and verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		numChecks++;
		if (g !== e) begin
			nMismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic endOfTest();
		$display("checks=%0d mismatches=%0d", numChecks, nMismatch);
		if (nMismatch == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// one apb transfer, idle edge after it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e);
	endtask
	// wait until the converter powers down
	task automatic waitIdle(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (convPowerOn === 1'b1 && n < 300);
		@(posedge mclk);
	endtask
	// reset values and an unmapped address
	task automatic tReset();
		rdChk(OFS_STATUS_CTRL, 32'h1F);
		rdChk(OFS_CONFIG, 32'h0);
		rdChk(OFS_PIN_LOW, 32'h0);
		rdChk(OFS_IRQ_MASK, 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		`CHK(err, 1'b1);
		`CHK(rd, 32'h0);
	endtask
	// every channel code below 24 reaches the mux and the result
	task automatic tChan();
		int n;
		for (int c = 0; c < 24; c++) begin
			apb(1'b1, OFS_STATUS_CTRL, 32'(c));
			`CHK(muxSel, c);
			waitIdle(n);
			rdChk(OFS_RESULT_LO, {c[2:0], 5'h0A});
		end
	endtask
	// single conversions with and without interrupt enable
	task automatic tSingle();
		int n;
		apb(1'b1, OFS_STATUS_CTRL, 32'h43);
		#1 `CHK(convPowerOn, 1'b1);
		waitIdle(n);
		rdChk(OFS_STATUS_CTRL, 32'hC3);
		`CHK({irq, convPowerOn}, 2'h2);
		rdChk(OFS_RESULT_LO, 32'h6A);
		rdChk(OFS_STATUS_CTRL, 32'h43);
		`CHK(irq, 1'b1);
		apb(1'b1, OFS_IRQ_STATUS, 32'h1);
		`CHK(irq, 1'b0);
		apb(1'b1, OFS_STATUS_CTRL, 32'h02);
		waitIdle(n);
		rdChk(OFS_STATUS_CTRL, 32'h82);
		`CHK(irq, 1'b0);
		apb(1'b1, OFS_STATUS_CTRL, 32'h1F);
		rdChk(OFS_STATUS_CTRL, 32'h1F);
	endtask
	// compare false keeps the flag clear, true sets it
	task automatic tCompare();
		int n;
		apb(1'b1, OFS_CONFIG, 32'h18);
		apb(1'b1, OFS_COMPARE, 32'h3FF);
		apb(1'b1, OFS_STATUS_CTRL, 32'h04);
		waitIdle(n);
		rdChk(OFS_STATUS_CTRL, 32'h04);
		apb(1'b1, OFS_COMPARE, 32'h0);
		apb(1'b1, OFS_STATUS_CTRL, 32'h04);
		waitIdle(n);
		rdChk(OFS_STATUS_CTRL, 32'h84);
		rdChk(OFS_RESULT_LO, 32'h8A);
		apb(1'b1, OFS_CONFIG, 32'h0);
	endtask
	// continuous runs on, off code stops it for good
	task automatic tCont();
		apb(1'b1, OFS_STATUS_CTRL, 32'h25);
		repeat (40) @(posedge mclk);
		rdChk(OFS_STATUS_CTRL, 32'hA5);
		rdChk(OFS_RESULT_LO, 32'hAA);
		repeat (40) @(posedge mclk);
		rdChk(OFS_STATUS_CTRL, 32'hA5);
		apb(1'b1, OFS_STATUS_CTRL, 32'h1F);
		`CHK({inputIsolate, convPowerOn}, 2'h2);
		repeat (40) @(posedge mclk);
		rdChk(OFS_STATUS_CTRL, 32'h1F);
	endtask
	// conversion time scales with each divide setting
	task automatic tDiv();
		int n;
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, OFS_CONFIG, 32'(d));
			apb(1'b1, OFS_STATUS_CTRL, 32'h01);
			waitIdle(n);
			`CHK(n > 11 * (1 << d) - 3 && n < 12 * (1 << d) + 3, 1'b1);
		end
	endtask
	// hardware start, ignored edge while busy, masking
	task automatic tHw();
		int n;
		apb(1'b1, OFS_CONFIG, 32'h04);
		apb(1'b1, OFS_STATUS_CTRL, 32'h46);
		#1 `CHK(convPowerOn, 1'b0);
		@(posedge mclk);
		trigReq <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 `CHK(convPowerOn, 1'b1);
		@(posedge mclk);
		trigReq <= 1'b0;
		repeat (2) @(posedge mclk);
		trigReq <= 1'b1;
		waitIdle(n);
		rdChk(OFS_IRQ_STATUS, 32'h3);
		`CHK(irq, 1'b1);
		apb(1'b1, OFS_IRQ_MASK, 32'h0);
		`CHK(irq, 1'b0);
		apb(1'b1, OFS_IRQ_STATUS, 32'h3);
		rdChk(OFS_IRQ_STATUS, 32'h0);
	endtask
	// pin disable bits cut drive, pull and read
	task automatic tPins();
		apb(1'b1, OFS_PIN_LOW, 32'h03);
		apb(1'b1, OFS_PIN_MID, 32'hFC);
		`CHK(padOutEnN, 16'hFC03);
		`CHK(padPullEn, 16'h03FC);
		`CHK(portReadData, 16'h03FC);
		rdChk(OFS_PIN_MID, 32'hFC);
		// port requests and pad levels that differ per pin
		portDriveEn <= 16'h00FF;
		padIn       <= 16'h0F0F;
		@(posedge mclk);
		#1 `CHK(padOutEnN, 16'hFF03);
		`CHK(portReadData, 16'h030C);
		`CHK(padPullEn, 16'h03FC);
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		tReset();
		tChan();
		tSingle();
		tCompare();
		tCont();
		tDiv();
		tHw();
		tPins();
		endOfTest();
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		nMismatch++;
		endOfTest();
	end
endmodule
bind acc_ctrl_top acc_ctrl_monitor #(.RES_W(RES_W), .PIN_N(PIN_N)) mon_u (
	.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .convPowerOn(convPowerOn),
	.muxSel(muxSel), .inputIsolate(inputIsolate),
	.portDriveEn(portDriveEn), .portPullEn(portPullEn), .padIn(padIn),
	.padOutEnN(padOutEnN), .padPullEn(padPullEn),
	.portReadData(portReadData));
